// ### serial_link_status_pll_config_test.sv
/*
  self-checking testbench: ahb-lite master into the host end, receiver
  state into the device end, checker beside the link.
  assumes nothing around it; clock 25 MHz.
*/
`timescale 1ns/1ns
`include "slr_regs.svh"
module serial_link_status_pll_config_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic [31:0] hrdata;
  logic ov = 1'b0;
  logic up = 1'b0;
  logic syr = 1'b0;
  logic lock = 1'b0;
  logic sub = 1'b1;
  logic tick;
  logic [7:0] mq;
  logic [3:0] lr;
  logic mfb;
  int n_errors = 0;
  int n_tests = 0;
  int n_sref = 0;
  int mf_gap = 0;
  int mf_last = 0;
  int g;
  int s;
  logic [31:0] res;
  logic [31:0] q;
  logic [7:0] legal [14] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0a,
    8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h28, 8'h30};
  logic [7:0] mcode [4] = '{8'h10, 8'h14, 8'h21, 8'h28};
  logic [3:0] lrx [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  slr_link_if slr_link_if_inst ();
  slr_host_end slr_host_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hrdata_o(hrdata), .hresp_o(), .link(slr_link_if_inst));
  slr_device_end slr_device_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .link(slr_link_if_inst), .overrun_event_i(ov), .buffer_released_i(up),
    .sync_request_i(syr), .serdes_locked_i(lock), .subclass1_i(sub),
    .pll_reference_tick_o(tick), .pll_mult_quarters_o(mq), .line_rate_halves_o(lr),
    .multiframe_boundary_o(mfb));
  slr_link_properties slr_link_properties_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req(slr_link_if_inst.req), .wr(slr_link_if_inst.wr), .addr(slr_link_if_inst.addr),
    .wdata(slr_link_if_inst.wdata), .rdata(slr_link_if_inst.rdata),
    .ack(slr_link_if_inst.ack), .sysref(slr_link_if_inst.sysref),
    .link_en(slr_link_if_inst.link_en), .sync_n(slr_link_if_inst.sync_n));
  always #20 clk_i = ~clk_i;
  always @(negedge clk_i) if (slr_link_if_inst.sysref === 1'b1) n_sref++;
  // spacing of multiframe boundary pulses
  always @(negedge clk_i) begin
    mf_gap++;
    if (mfb === 1'b1) begin
      mf_last = mf_gap;
      mf_gap = 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic r;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(negedge clk_i);
      r = hready;
      @(posedge clk_i);
    end while (!r);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge clk_i);
      r = hready;
      q = hrdata;
      @(posedge clk_i);
    end while (!r);
  endtask
  // device access through the command register, result left in res
  task automatic dev(input logic w, input logic [11:0] a, input logic [7:0] d);
    ahb(1'b1, `SLR_HOF_CMD, {11'h000, w, d, a});
    do ahb(1'b0, `SLR_HOF_RESULT, 32'h0000_0000);
    while (q[`SLR_RES_BUSY] !== 1'b0);
    res = q;
  endtask
  task automatic tick_gap();
    repeat (2) do @(negedge clk_i); while (tick !== 1'b1);
    g = 0;
    do begin
      @(negedge clk_i);
      g++;
    end while (tick !== 1'b1);
    @(posedge clk_i);
  endtask
  function automatic logic [9:0] st(input logic o, input logic r, input logic a);
    return {2'h0, o, up, !syr, r, a, lock, 2'h0};
  endfunction
  task automatic give_verdict();
    $display("counts: tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h5197));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    dev(1'b0, `SLR_OFS_DIVISOR, 8'h00);
    chk(res[9:0], 10'h030);
    dev(1'b0, `SLR_OFS_MULT, 8'h00);
    chk(res[9:0], 10'h014);
    dev(1'b0, `SLR_OFS_RATE, 8'h00);
    chk(res[9:0], 10'h000);
    ahb(1'b1, 8'h0c, $urandom);
    ahb(1'b0, 8'h0c, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("done: reset values");
    s = $urandom_range(13);
    for (int i = 0; i < 14; i++) begin
      dev(1'b1, `SLR_OFS_DIVISOR, legal[(i + s) % 14]);
      dev(1'b0, `SLR_OFS_DIVISOR, 8'h00);
      chk(res[9:0], {2'h0, legal[(i + s) % 14]});
      tick_gap();
      chk(g, legal[(i + s) % 14]);
    end
    dev(1'b1, `SLR_OFS_DIVISOR, 8'h07);
    chk(res[9], 1'b1);
    dev(1'b1, `SLR_OFS_DIVISOR, 8'h10);
    chk(mf_last, `SLR_MF_LEN);
    $display("done: divider");
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, `SLR_OFS_MULT, mcode[i]);
      chk(mq, mcode[i]);
      dev(1'b1, `SLR_OFS_RATE, {6'($urandom), 2'(i)});
      dev(1'b0, `SLR_OFS_RATE, 8'h00);
      chk(res[9:0], 10'(i));
      chk(lr, lrx[i]);
    end
    dev(1'b1, `SLR_OFS_MULT, 8'h11);
    chk(mq, 8'h00);
    dev(1'b1, `SLR_OFS_MULT, 8'h28);
    $display("done: multipliers");
    up <= 1'b1;
    lock <= 1'b1;
    ov <= 1'b1;
    @(posedge clk_i);
    ov <= 1'b0;
    dev(1'b0, `SLR_OFS_STATUS, 8'h00);
    chk(res[9:0], st(1'b1, 1'b0, 1'b0));
    dev(1'b1, `SLR_OFS_STATUS, 8'(8'h6f & $urandom));
    dev(1'b0, `SLR_OFS_STATUS, 8'h00);
    chk(res[9:0], st(1'b1, 1'b0, 1'b0));
    dev(1'b1, `SLR_OFS_STATUS, 8'h80);
    up <= 1'b0;
    lock <= 1'b0;
    syr <= 1'b1;
    dev(1'b0, `SLR_OFS_STATUS, 8'h00);
    chk(res[9:0], st(1'b0, 1'b0, 1'b0));
    syr <= 1'b0;
    $display("done: status");
    // divisor three never divides the sysref gap: every pulse realigns
    dev(1'b1, `SLR_OFS_DIVISOR, 8'h03);
    ahb(1'b1, `SLR_HOF_CTRL, 32'h0000_0003);
    repeat (600) @(posedge clk_i);
    chk(n_sref, 7);
    dev(1'b0, `SLR_OFS_STATUS, 8'h00);
    chk(res[9:0], st(1'b0, 1'b1, 1'b0));
    ahb(1'b1, `SLR_HOF_CTRL, 32'h0000_0000);
    dev(1'b1, `SLR_OFS_DIVISOR, 8'h10);
    ahb(1'b1, `SLR_HOF_CTRL, 32'h0000_0003);
    repeat (600) @(posedge clk_i);
    chk(n_sref, 14);
    dev(1'b0, `SLR_OFS_STATUS, 8'h00);
    chk(res[9:0], st(1'b0, 1'b1, 1'b1));
    dev(1'b1, `SLR_OFS_MULT, 8'h10);
    chk(res[9], 1'b1);
    dev(1'b0, `SLR_OFS_MULT, 8'h00);
    chk(res[9:0], 10'h028);
    dev(1'b1, `SLR_OFS_STATUS, 8'hff);
    dev(1'b0, `SLR_OFS_STATUS, 8'h00);
    chk(res[9:0], st(1'b0, 1'b0, 1'b1));
    sub <= 1'b0;
    dev(1'b0, `SLR_OFS_STATUS, 8'h00);
    chk(res[9:0], st(1'b0, 1'b0, 1'b0));
    ahb(1'b1, `SLR_HOF_CTRL, 32'h0000_0000);
    $display("done: sysref");
    give_verdict();
  end
endmodule

// ### slr_device_end.sv
/*
  device end: link status register, phy pll reference divider, pll
  multiplier and line rate registers, sysref phase check.
  assumes the controller keeps req high until it sees ack, and that all
  user-side inputs are synchronous to clk_i.
*/
// Added by the designer: the link register port.
// Contract
// - overrun flag sets on buffer error, write-one clears
// - link-up bit reads buffer released, read-only
// - sync bit reads zero while sync asserted
// - realign flag sets on sysref realign, write-one clears
// - consistent bit shows last sysref matched phase
// - consistent bit cannot be cleared by software
// - controller sends up to seven sysref pulses
// - realign and consistent undefined in subclass zero
// - lock bit high only when all plls locked
// - reference clock is sample clock over divisor
// - divisor only legal values two to forty-eight
// - multiplier code selects four, five, 8.25, ten
// - change multiplier only while link disabled
// - rate code selects four, two, one, half
`timescale 1ns/1ns
`include "slr_regs.svh"
module slr_device_end (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // link side
  slr_link_if.dev link,
  // receiver state
  input wire logic overrun_event_i,
  input wire logic buffer_released_i,
  input wire logic sync_request_i,
  input wire logic serdes_locked_i,
  input wire logic subclass1_i,
  // phy pll configuration
  output logic pll_reference_tick_o,
  output logic [7:0] pll_mult_quarters_o,
  output logic [3:0] line_rate_halves_o,
  output logic multiframe_boundary_o
);
  logic elastic_overrun_flag;
  logic realign_flag;
  logic sysref_consistent;
  logic link_up;
  logic sync_line_level;
  logic pll_locked;
  logic [5:0] phy_ref_divisor;
  slr_pkg::slr_byte_t phy_pll_multiplier;
  logic [1:0] line_rate_code;
  slr_pkg::slr_byte_t rdata;
  logic ack;
  logic sysref_d;
  logic ref_tick;
  slr_pkg::slr_byte_t mult_q;
  logic [3:0] rate_h;
  logic mf_tick;

  logic next_elastic_overrun_flag;
  logic next_realign_flag;
  logic next_sysref_consistent;
  logic [5:0] next_phy_ref_divisor;
  slr_pkg::slr_byte_t next_phy_pll_multiplier;
  logic [1:0] next_line_rate_code;
  slr_pkg::slr_byte_t next_rdata;
  logic next_ack;
  slr_pkg::slr_byte_t next_mult_q;
  logic [3:0] next_rate_h;

  logic access;
  logic wr_status;
  logic sysref_edge;
  logic realign;
  logic [5:0] ref_count;
  logic [7:0] mf_count;
  logic ref_wrap;
  logic mf_wrap;
  slr_pkg::slr_byte_t status_word;

  assign access = link.req & ~ack;
  assign wr_status = access & link.wr & (link.addr == `SLR_OFS_STATUS);
  assign sysref_edge = link.sysref & ~sysref_d;
  assign realign = sysref_edge & ((ref_count != '0) | (mf_count != '0));

  // reference divider and multiframe counter, both phased by sysref
  slr_phase_div #(.W(6)) u_ref_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(realign),
    .modulus_i(phy_ref_divisor),
    .count_o(ref_count),
    .wrap_o(ref_wrap)
  );

  slr_phase_div #(.W(8)) u_mf_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(realign),
    .modulus_i(`SLR_MF_LEN),
    .count_o(mf_count),
    .wrap_o(mf_wrap)
  );

  always_comb begin
    status_word = 8'h00;
    status_word[`SLR_ST_OVERRUN] = elastic_overrun_flag;
    status_word[`SLR_ST_LINK_UP] = link_up;
    status_word[`SLR_ST_SYNC] = sync_line_level;
    status_word[`SLR_ST_REALIGN] = realign_flag;
    status_word[`SLR_ST_CONSIST] = sysref_consistent;
    status_word[`SLR_ST_LOCK] = pll_locked;
  end

  // status flags; a set in the same cycle as a clear wins
  always_comb begin
    next_elastic_overrun_flag = overrun_event_i |
      (elastic_overrun_flag & ~(wr_status & link.wdata[`SLR_ST_OVERRUN]));
    next_realign_flag = realign_flag & ~(wr_status & link.wdata[`SLR_ST_REALIGN]);
    next_sysref_consistent = sysref_consistent;
    if (realign) begin
      next_realign_flag = 1'b1;
    end
    if (sysref_edge) begin
      next_sysref_consistent = ~realign;
    end
    if (!link.link_en || !subclass1_i) begin
      next_sysref_consistent = 1'b0;
    end
    if (!subclass1_i) begin
      next_realign_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      elastic_overrun_flag <= 1'b0;
      realign_flag <= 1'b0;
      sysref_consistent <= 1'b0;
      link_up <= 1'b0;
      sync_line_level <= 1'b1;
      pll_locked <= 1'b0;
      sysref_d <= 1'b0;
    end else if (ce_i) begin
      elastic_overrun_flag <= next_elastic_overrun_flag;
      realign_flag <= next_realign_flag;
      sysref_consistent <= next_sysref_consistent;
      link_up <= buffer_released_i;
      sync_line_level <= ~sync_request_i;
      pll_locked <= serdes_locked_i;
      sysref_d <= link.sysref;
    end
  end

  // configuration registers and register port
  always_comb begin
    next_phy_ref_divisor = phy_ref_divisor;
    next_phy_pll_multiplier = phy_pll_multiplier;
    next_line_rate_code = line_rate_code;
    next_ack = access;
    next_rdata = rdata;
    if (access && link.wr) begin
      case (link.addr)
        `SLR_OFS_DIVISOR: next_phy_ref_divisor = link.wdata[5:0];
        `SLR_OFS_MULT: next_phy_pll_multiplier = link.wdata;
        `SLR_OFS_RATE: next_line_rate_code = link.wdata[1:0];
        default: next_rdata = rdata;
      endcase
    end else if (access) begin
      case (link.addr)
        `SLR_OFS_STATUS: next_rdata = status_word;
        `SLR_OFS_DIVISOR: next_rdata = {2'b00, phy_ref_divisor};
        `SLR_OFS_MULT: next_rdata = phy_pll_multiplier;
        `SLR_OFS_RATE: next_rdata = {6'h00, line_rate_code};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // factor decode for the pll and line rate
  always_comb begin
    case (phy_pll_multiplier)
      `SLR_MULT_C4: next_mult_q = `SLR_MQ_4;
      `SLR_MULT_C5: next_mult_q = `SLR_MQ_5;
      `SLR_MULT_C8Q: next_mult_q = `SLR_MQ_8Q;
      `SLR_MULT_C10: next_mult_q = `SLR_MQ_10;
      default: next_mult_q = 8'h00;
    endcase
    case (line_rate_code)
      2'b00: next_rate_h = `SLR_LR_X4;
      2'b01: next_rate_h = `SLR_LR_X2;
      2'b10: next_rate_h = `SLR_LR_X1;
      default: next_rate_h = `SLR_LR_XH;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_ref_divisor <= 6'(`SLR_RST_DIVISOR);
      phy_pll_multiplier <= `SLR_RST_MULT;
      line_rate_code <= 2'(`SLR_RST_RATE);
      ack <= 1'b0;
      rdata <= 8'h00;
      mult_q <= `SLR_MQ_5;
      rate_h <= `SLR_LR_X4;
      ref_tick <= 1'b0;
      mf_tick <= 1'b0;
    end else if (ce_i) begin
      phy_ref_divisor <= next_phy_ref_divisor;
      phy_pll_multiplier <= next_phy_pll_multiplier;
      line_rate_code <= next_line_rate_code;
      ack <= next_ack;
      rdata <= next_rdata;
      mult_q <= next_mult_q;
      rate_h <= next_rate_h;
      ref_tick <= ref_wrap;
      mf_tick <= mf_wrap;
    end
  end

  assign link.ack = ack;
  assign link.rdata = rdata;
  assign link.sync_n = sync_line_level;
  assign pll_reference_tick_o = ref_tick;
  assign pll_mult_quarters_o = mult_q;
  assign line_rate_halves_o = rate_h;
  assign multiframe_boundary_o = mf_tick;
endmodule

// ### slr_host_end.sv
/*
  controller end: ahb-lite slave with control, command and result
  registers; runs register transfers on the link and sysref bursts.
  assumes a single ahb master and the device end on the same clock.
*/
`timescale 1ns/1ns
`include "slr_regs.svh"
module slr_host_end (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  // link side
  slr_link_if.host link
);
  slr_pkg::slr_xfer_state_t state;
  slr_pkg::slr_xfer_state_t next_state;
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [20:0] cmd;
  logic [20:0] next_cmd;
  slr_pkg::slr_byte_t result;
  slr_pkg::slr_byte_t next_result;
  logic refused;
  logic next_refused;
  logic req;
  logic next_req;
  logic dphase_wr;
  logic [7:0] dphase_addr;
  logic [31:0] rd;
  logic [31:0] next_rd;
  logic [2:0] pulses_left;
  logic [2:0] next_pulses_left;
  logic sysref;
  logic next_sysref;
  logic link_en_d;
  logic gap_wrap;
  logic addr_phase;
  logic cmd_wr;
  logic bad;

  assign addr_phase = hsel_i & htrans_i[1] & hready_i;
  assign cmd_wr = dphase_wr & (dphase_addr == `SLR_HOF_CMD);

  function automatic logic div_legal(input logic [5:0] v);
    case (v)
      6'd2, 6'd3, 6'd4, 6'd5, 6'd6, 6'd8, 6'd10, 6'd12,
      6'd16, 6'd20, 6'd24, 6'd32, 6'd40, 6'd48: div_legal = 1'b1;
      default: div_legal = 1'b0;
    endcase
  endfunction

  always_comb begin
    bad = 1'b0;
    if (hwdata_i[`SLR_CMD_WR] && hwdata_i[11:0] == `SLR_OFS_MULT && ctrl[`SLR_CTRL_LINK_EN]) begin
      bad = 1'b1;
    end
    if (hwdata_i[`SLR_CMD_WR] && hwdata_i[11:0] == `SLR_OFS_DIVISOR &&
        !div_legal(hwdata_i[17:12])) begin
      bad = 1'b1;
    end
  end

  // bus registers and transfer sequencer
  always_comb begin
    next_ctrl = ctrl;
    next_cmd = cmd;
    next_state = state;
    next_req = req;
    next_result = result;
    next_refused = refused;
    next_rd = rd;
    if (dphase_wr && dphase_addr == `SLR_HOF_CTRL) begin
      next_ctrl = hwdata_i[1:0];
    end
    case (state)
      slr_pkg::SLR_IDLE: begin
        if (cmd_wr) begin
          next_refused = bad;
          if (!bad) begin
            next_cmd = hwdata_i[20:0];
            next_req = 1'b1;
            next_state = slr_pkg::SLR_WAIT;
          end
        end
      end
      slr_pkg::SLR_WAIT: begin
        if (link.ack) begin
          next_req = 1'b0;
          next_result = link.rdata;
          next_state = slr_pkg::SLR_DONE;
        end
      end
      slr_pkg::SLR_DONE: next_state = slr_pkg::SLR_IDLE;
      default: next_state = slr_pkg::SLR_IDLE;
    endcase
    if (cmd_wr && state != slr_pkg::SLR_IDLE) begin
      next_refused = 1'b1;
    end
    if (addr_phase) begin
      case (haddr_i)
        `SLR_HOF_CTRL: next_rd = {30'h0000_0000, ctrl};
        `SLR_HOF_CMD: next_rd = {11'h000, cmd};
        `SLR_HOF_RESULT: next_rd = {22'h00_0000, refused, state != slr_pkg::SLR_IDLE, result};
        default: next_rd = 32'h0000_0000;
      endcase
    end
  end

  // sysref burst after link enable rises, only when burst enable is set
  slr_phase_div #(.W(8)) u_gap (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(1'b0),
    .modulus_i(`SLR_SYSREF_GAP),
    .count_o(),
    .wrap_o(gap_wrap)
  );

  always_comb begin
    next_pulses_left = pulses_left;
    next_sysref = 1'b0;
    if (ctrl[`SLR_CTRL_LINK_EN] && !link_en_d && ctrl[`SLR_CTRL_BURST_EN]) begin
      next_pulses_left = `SLR_SYSREF_PULSES;
    end else if (gap_wrap && pulses_left != 3'h0) begin
      next_sysref = 1'b1;
      next_pulses_left = 3'(pulses_left - 3'h1);
    end
    if (!ctrl[`SLR_CTRL_LINK_EN]) begin
      next_pulses_left = 3'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= slr_pkg::SLR_IDLE;
      ctrl <= 2'b00;
      cmd <= 21'h00_0000;
      result <= 8'h00;
      refused <= 1'b0;
      req <= 1'b0;
      dphase_wr <= 1'b0;
      dphase_addr <= 8'h00;
      rd <= 32'h0000_0000;
      pulses_left <= 3'h0;
      sysref <= 1'b0;
      link_en_d <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      ctrl <= next_ctrl;
      cmd <= next_cmd;
      result <= next_result;
      refused <= next_refused;
      req <= next_req;
      dphase_wr <= addr_phase & hwrite_i & (hsize_i == 3'b010);
      dphase_addr <= haddr_i;
      rd <= next_rd;
      pulses_left <= next_pulses_left;
      sysref <= next_sysref;
      link_en_d <= ctrl[`SLR_CTRL_LINK_EN];
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  assign hrdata_o = rd;
  assign link.req = req;
  assign link.wr = cmd[`SLR_CMD_WR];
  assign link.addr = cmd[11:0];
  assign link.wdata = cmd[19:12];
  assign link.sysref = sysref;
  assign link.link_en = ctrl[`SLR_CTRL_LINK_EN];
endmodule

// ### slr_link_if.sv
/*
  register port and link signals between the controller and the device.
  assumes both ends share clk_i; the testbench instantiates it.
*/
`timescale 1ns/1ns
interface slr_link_if;
  logic req;
  logic wr;
  slr_pkg::slr_addr_t addr;
  slr_pkg::slr_byte_t wdata;
  slr_pkg::slr_byte_t rdata;
  logic ack;
  logic sysref;
  logic link_en;
  logic sync_n;
  modport dev (
    input req, wr, addr, wdata, sysref, link_en,
    output rdata, ack, sync_n
  );
  modport host (
    output req, wr, addr, wdata, sysref, link_en,
    input rdata, ack, sync_n
  );
endinterface

// ### slr_link_properties.sv
/*
  checker for the link between both ends: port handshake, readback, sysref.
  assumes one clock for both ends and clock enable held high.
*/
`timescale 1ns/1ns
`include "slr_regs.svh"
module slr_link_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link signals
  input wire logic req,
  input wire logic wr,
  input wire slr_pkg::slr_addr_t addr,
  input wire slr_pkg::slr_byte_t wdata,
  input wire slr_pkg::slr_byte_t rdata,
  input wire logic ack,
  input wire logic sysref,
  input wire logic link_en,
  input wire logic sync_n
);
  logic [7:0] div_w;
  logic [7:0] next_div_w;
  logic [1:0] rate_w;
  logic [1:0] next_rate_w;
  logic [3:0] n_sr;
  logic [3:0] next_n_sr;
  logic [1:0] sy_d;
  logic [1:0] next_sy_d;
  logic [1:0] en_d;
  logic [1:0] next_en_d;
  logic st_rd;
  logic wr_ack;
  assign st_rd = ack && !wr && addr == `SLR_OFS_STATUS;
  assign wr_ack = ack && wr;
  // shadow of written config, sysref pulses since enable, input history
  always_comb begin
    next_div_w = div_w;
    next_rate_w = rate_w;
    next_n_sr = link_en ? n_sr + {3'h0, sysref} : 4'h0;
    next_sy_d = {sy_d[0], sync_n};
    next_en_d = {en_d[0], link_en};
    if (wr_ack && addr == `SLR_OFS_DIVISOR) begin
      next_div_w = wdata;
    end
    if (wr_ack && addr == `SLR_OFS_RATE) begin
      next_rate_w = wdata[1:0];
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_w <= `SLR_RST_DIVISOR;
      rate_w <= 2'h0;
      n_sr <= 4'h0;
      sy_d <= 2'h3;
      en_d <= 2'h0;
    end else begin
      div_w <= next_div_w;
      rate_w <= next_rate_w;
      n_sr <= next_n_sr;
      sy_d <= next_sy_d;
      en_d <= next_en_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_timing: assert property (req && !ack |=> ack && req && $stable(addr) && $stable(wdata))
    else $error("ack not one cycle after request");
  a_ack_release: assert property (ack |=> !ack && !req)
    else $error("ack or request held too long");
  a_status_rsvd: assert property (st_rd |-> rdata[1:0] == 2'h0)
    else $error("reserved status bits not zero");
  a_sync_bit: assert property (st_rd && sy_d == {2{sync_n}} |-> rdata[5] == sync_n)
    else $error("sync bit differs from sync line");
  a_consist_off: assert property (st_rd && en_d == 2'h0 && !link_en |-> !rdata[3])
    else $error("consistent bit set with link disabled");
  a_divisor_back: assert property (ack && !wr && addr == `SLR_OFS_DIVISOR |->
    rdata == {2'h0, div_w[5:0]})
    else $error("divisor readback wrong");
  a_rate_back: assert property (ack && !wr && addr == `SLR_OFS_RATE |->
    rdata == {6'h00, rate_w})
    else $error("rate readback wrong");
  a_sysref_pulse: assert property (sysref |=> (!sysref) [*8])
    else $error("sysref pulse too long or too close");
  a_sysref_en: assert property (sysref |-> link_en)
    else $error("sysref while link disabled");
  a_burst_max: assert property (n_sr <= 4'h7)
    else $error("more than seven sysref pulses");
  c_sysref_consistent: cover property (st_rd && rdata[3]);
  c_write: cover property (wr_ack);
  c_burst: cover property (n_sr == 4'h7);
endmodule

// ### slr_phase_div.sv
/*
  free running modulo counter with phase clear; wrap pulses at count modulus-1.
  assumes a modulus of at least 2 and synchronous inputs.
*/
`timescale 1ns/1ns
module slr_phase_div #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // control
  input wire logic clear_i,
  input wire logic [W-1:0] modulus_i,
  // status
  output logic [W-1:0] count_o,
  output logic wrap_o
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  assign wrap_o = ce_i & ~clear_i & (count == W'(modulus_i - W'(1)));
  assign count_o = count;

  always_comb begin
    next_count = count;
    if (clear_i) begin
      // the clearing cycle itself counts as phase zero
      next_count = (modulus_i > W'(1)) ? W'(1) : '0;
    end else if (wrap_o || count >= modulus_i) begin
      next_count = '0;
    end else begin
      next_count = W'(count + W'(1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (ce_i) begin
      count <= next_count;
    end
  end
endmodule

// ### slr_pkg.sv
/*
  types shared by both ends of the link.
  assumes nothing of its surroundings.
*/
package slr_pkg;
  typedef logic [7:0] slr_byte_t;
  typedef logic [11:0] slr_addr_t;
  typedef enum logic [1:0] {
    SLR_IDLE = 2'b00,
    SLR_WAIT = 2'b01,
    SLR_DONE = 2'b11
  } slr_xfer_state_t;
endpackage

// ### slr_regs.svh
/*
  register offsets, field positions, reset values and counts for the
  serial link status and phy pll configuration block.
  assumes inclusion by bare name from any design file.
*/
`ifndef SLR_REGS_SVH
`define SLR_REGS_SVH
// device register offsets
`define SLR_OFS_STATUS 12'h107
`define SLR_OFS_DIVISOR 12'h108
`define SLR_OFS_MULT 12'h109
`define SLR_OFS_RATE 12'h10a
// link_status bit positions
`define SLR_ST_OVERRUN 7
`define SLR_ST_LINK_UP 6
`define SLR_ST_SYNC 5
`define SLR_ST_REALIGN 4
`define SLR_ST_CONSIST 3
`define SLR_ST_LOCK 2
// reset values
`define SLR_RST_DIVISOR 8'h30
`define SLR_RST_MULT 8'h14
`define SLR_RST_RATE 8'h00
// multiplier codes and their factors in quarters
`define SLR_MULT_C4 8'h10
`define SLR_MULT_C5 8'h14
`define SLR_MULT_C8Q 8'h21
`define SLR_MULT_C10 8'h28
`define SLR_MQ_4 8'h10
`define SLR_MQ_5 8'h14
`define SLR_MQ_8Q 8'h21
`define SLR_MQ_10 8'h28
// line rate factors in halves
`define SLR_LR_X4 4'h8
`define SLR_LR_X2 4'h4
`define SLR_LR_X1 4'h2
`define SLR_LR_XH 4'h1
// multiframe length in cycles, sysref burst
`define SLR_MF_LEN 8'h20
`define SLR_SYSREF_PULSES 3'h7
`define SLR_SYSREF_GAP 8'h40
// host registers on the ahb-lite side
`define SLR_HOF_CTRL 8'h00
`define SLR_HOF_CMD 8'h04
`define SLR_HOF_RESULT 8'h08
`define SLR_CTRL_LINK_EN 0
`define SLR_CTRL_BURST_EN 1
`define SLR_CMD_WR 20
`define SLR_RES_BUSY 8
`define SLR_RES_REFUSED 9
`endif
